// file: dmis_map.svh
`ifndef DMIS_MAP_SVH
`define DMIS_MAP_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DMIS_CLK_PERIOD_NS 40
`define DMIS_SELFINIT_US   500
`define DMIS_SELFINIT_CYC  ((`DMIS_SELFINIT_US * 1000 + `DMIS_CLK_PERIOD_NS - 1) / `DMIS_CLK_PERIOD_NS)
`define DMIS_LOCK_CYC      512
`define DMIS_CAL_CYC       512
`define DMIS_PRECHARGE_CYC 4

// ----------------------------------------------------------------
// Bank select codes for mode loads
// ----------------------------------------------------------------
`define DMIS_BANK_ZERO  2'h0
`define DMIS_BANK_ONE   2'h1
`define DMIS_BANK_TWO   2'h2
`define DMIS_BANK_THREE 2'h3
`define DMIS_BANK_HI  2

// ----------------------------------------------------------------
// Mode register field positions
// ----------------------------------------------------------------
`define DMIS_BL_MSB      1
`define DMIS_BL_LSB      0
`define DMIS_BT_BIT      3
`define DMIS_CAS_LO_BIT  2
`define DMIS_CAS_MSB     6
`define DMIS_CAS_LSB     4
`define DMIS_TM_BIT      7
`define DMIS_DLLRST_BIT  8
`define DMIS_WR_MSB      11
`define DMIS_WR_LSB      9
`define DMIS_DLLOFF_BIT  0
`define DMIS_ADDLAT_MSB  4
`define DMIS_ADDLAT_LSB  3
`define DMIS_ZQ_LONG_BIT 10
`define DMIS_CAS_BASE    5'h04

`endif

// file: dmis_pkg.sv
package dmis_pkg;

    // ----------------------------------------------------------------
    // Sequencer states, Gray coded along the power-up path
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_RESET    = 3'h0,
        ST_SELFINIT = 3'h1,
        ST_WAIT_CKE = 3'h3,
        ST_MODE     = 3'h2,
        ST_READY    = 3'h6
    } dmis_state_t;

    // ----------------------------------------------------------------
    // Command pins sampled on each clock
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  bank_select;
        logic [15:0] addr;
    } dmis_cmd_t;

    // ----------------------------------------------------------------
    // Decoded operating settings
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] burst_len;
        logic       burst_interleave;
        logic [4:0] cas_latency;
        logic [4:0] additive_latency;
        logic [5:0] read_latency;
        logic [4:0] write_recovery;
        logic [7:0] autoprecharge_write_delay;
        logic       dll_disabled;
        logic       test_mode;
    } dmis_fields_t;

endpackage : dmis_pkg

// file: dmis_seq.sv
// Contract
// - After reset release 500us pass, memory self-initialises before clock gate rises.
// - Termination stays high impedance in reset and until clock gate registers high.
// - Bank select bits zero..three pick mode register zero..three.
// - Four mode registers start undefined; all must be written after each reset.
// - Mode loads and DLL reset leave array contents untouched.
// - Write recovery field plus precharge period gives the auto-precharge write delay.
// - CAS latency from bits 2 and 4..6, whole cycles; read latency is additive plus CAS.
// - DLL reset bit clears itself after the DLL reset is issued.
// - Bits 0..1 select burst length, bit 3 selects burst type.
// - Write recovery sits in register zero bits 9..11.
`include "dmis_map.svh"

module dmis_seq #(
    parameter int unsigned SELFINIT_CYC  = `DMIS_SELFINIT_CYC,
    parameter int unsigned LOCK_CYC      = `DMIS_LOCK_CYC,
    parameter int unsigned CAL_CYC       = `DMIS_CAL_CYC,
    parameter int unsigned PRECHARGE_CYC = `DMIS_PRECHARGE_CYC,
    parameter int unsigned CNT_W         = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic                  chip_reset_n,
    input  wire logic                  cke,
    input  wire dmis_pkg::dmis_cmd_t   cmd,
    output logic                       termination_hiz,
    output logic                       ready,
    output logic                       self_init_done,
    output logic                       lock_busy,
    output logic                       cal_busy,
    output logic [3:0]                 mode_written,
    output logic [15:0]                mode_reg_zero,
    output logic [15:0]                mode_reg_one,
    output logic [15:0]                mode_reg_two,
    output logic [15:0]                mode_reg_three,
    output dmis_pkg::dmis_fields_t     fields,
    output dmis_pkg::dmis_state_t      state
);
    import dmis_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (SELFINIT_CYC < 1 || SELFINIT_CYC >= (1 << CNT_W) || LOCK_CYC >= (1 << CNT_W)
        || CAL_CYC >= (1 << CNT_W) || PRECHARGE_CYC > 64 || CNT_W > 31)
    begin : g_bad_param
        $error("dmis_seq: count parameters out of range");
    end

    localparam logic [CNT_W-1:0] SELFINIT_LAST = CNT_W'(SELFINIT_CYC - 1);
    localparam logic [CNT_W-1:0] LOCK_LOAD     = CNT_W'(LOCK_CYC);
    localparam logic [CNT_W-1:0] CAL_LOAD      = CNT_W'(CAL_CYC);
    localparam logic [7:0]       PRECH_LOAD    = 8'(PRECHARGE_CYC);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0]      mreg [4];
    logic [15:0]      next_mreg [4];
    dmis_state_t      next_state;
    logic [CNT_W-1:0] init_cnt, next_init_cnt;
    logic [CNT_W-1:0] lock_cnt, next_lock_cnt;
    logic [CNT_W-1:0] cal_cnt, next_cal_cnt;
    logic             lock_ran, next_lock_ran;
    logic             cal_ran, next_cal_ran;
    logic [3:0]       next_mode_written;
    logic             next_termination_hiz;
    dmis_fields_t     next_fields;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic       cmd_live;
    logic       is_mode_load;
    logic       is_cal_long;
    logic [1:0] target;

    always_comb
    begin
        cmd_live     = cke && !cmd.cs_n && (state == ST_MODE || state == ST_READY);
        is_mode_load = cmd_live && !cmd.ras_n && !cmd.cas_n && !cmd.we_n
                       && !cmd.bank_select[`DMIS_BANK_HI];
        is_cal_long  = cmd_live && cmd.ras_n && cmd.cas_n && !cmd.we_n
                       && cmd.addr[`DMIS_ZQ_LONG_BIT];
        target       = cmd.bank_select[1:0];
    end

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state           = state;
        next_init_cnt        = init_cnt;
        next_lock_cnt        = lock_cnt;
        next_cal_cnt         = cal_cnt;
        next_lock_ran        = lock_ran;
        next_cal_ran         = cal_ran;
        next_mode_written    = mode_written;
        next_termination_hiz = termination_hiz;
        for (int i = 0; i < 4; i++)
        begin
            next_mreg[i] = mreg[i];
        end
        if (!chip_reset_n)
        begin
            next_state           = ST_RESET;
            next_init_cnt        = '0;
            next_lock_cnt        = '0;
            next_cal_cnt         = '0;
            next_lock_ran        = 1'b0;
            next_cal_ran         = 1'b0;
            next_mode_written    = 4'h0;
            next_termination_hiz = 1'b1;
        end
        else
        begin
            if (lock_cnt != '0)
            begin
                next_lock_cnt = lock_cnt - CNT_W'(1);
            end
            if (cal_cnt != '0)
            begin
                next_cal_cnt = cal_cnt - CNT_W'(1);
            end
            case (state)
                ST_RESET:
                begin
                    next_init_cnt = '0;
                    next_state    = ST_SELFINIT;
                end
                ST_SELFINIT:
                begin
                    next_init_cnt = init_cnt + CNT_W'(1);
                    if (init_cnt == SELFINIT_LAST)
                    begin
                        next_state = ST_WAIT_CKE;
                    end
                end
                ST_WAIT_CKE:
                begin
                    if (cke)
                    begin
                        next_termination_hiz = 1'b0;
                        next_state           = ST_MODE;
                    end
                end
                ST_MODE, ST_READY:
                begin
                    if (is_mode_load)
                    begin
                        // Array is never touched here
                        next_mreg[target]         = cmd.addr;
                        next_mode_written[target] = 1'b1;
                        if (target == `DMIS_BANK_ZERO && cmd.addr[`DMIS_DLLRST_BIT])
                        begin
                            next_mreg[target][`DMIS_DLLRST_BIT] = 1'b0;
                            next_lock_cnt = LOCK_LOAD;
                            next_lock_ran = 1'b1;
                        end
                    end
                    if (is_cal_long)
                    begin
                        next_cal_cnt = CAL_LOAD;
                        next_cal_ran = 1'b1;
                    end
                    if (state == ST_MODE && mode_written == 4'hF && lock_ran && cal_ran
                        && lock_cnt == '0 && cal_cnt == '0)
                    begin
                        next_state = ST_READY;
                    end
                end
                default:
                begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    function automatic logic [4:0] dmis_wr_decode(input logic [2:0] code);
        case (code)
            3'h1:    dmis_wr_decode = 5'h05;
            3'h2:    dmis_wr_decode = 5'h06;
            3'h3:    dmis_wr_decode = 5'h07;
            3'h4:    dmis_wr_decode = 5'h08;
            3'h5:    dmis_wr_decode = 5'h0A;
            3'h6:    dmis_wr_decode = 5'h0C;
            3'h7:    dmis_wr_decode = 5'h0E;
            default: dmis_wr_decode = 5'h10;
        endcase
    endfunction : dmis_wr_decode

    always_comb
    begin
        next_fields.burst_len        = next_mreg[0][`DMIS_BL_MSB:`DMIS_BL_LSB];
        next_fields.burst_interleave = next_mreg[0][`DMIS_BT_BIT];
        next_fields.cas_latency      = 5'({next_mreg[0][`DMIS_CAS_LO_BIT],
                                         next_mreg[0][`DMIS_CAS_MSB:`DMIS_CAS_LSB]})
                                       + `DMIS_CAS_BASE;
        case (next_mreg[1][`DMIS_ADDLAT_MSB:`DMIS_ADDLAT_LSB])
            2'h1:    next_fields.additive_latency = next_fields.cas_latency - 5'h01;
            2'h2:    next_fields.additive_latency = next_fields.cas_latency - 5'h02;
            default: next_fields.additive_latency = 5'h00;
        endcase
        next_fields.read_latency = 6'(next_fields.additive_latency)
                                   + 6'(next_fields.cas_latency);
        next_fields.write_recovery = dmis_wr_decode(
            next_mreg[0][`DMIS_WR_MSB:`DMIS_WR_LSB]);
        next_fields.autoprecharge_write_delay = 8'(next_fields.write_recovery)
                                                + PRECH_LOAD;
        next_fields.dll_disabled = next_mreg[1][`DMIS_DLLOFF_BIT];
        next_fields.test_mode    = next_mreg[0][`DMIS_TM_BIT];
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_mreg
        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
            begin
                mreg[g] <= 16'h0000;
            end
            else if (clk_en)
            begin
                mreg[g] <= next_mreg[g];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state           <= ST_RESET;
            init_cnt        <= '0;
            lock_cnt        <= '0;
            cal_cnt         <= '0;
            lock_ran        <= 1'b0;
            cal_ran         <= 1'b0;
            mode_written    <= 4'h0;
            termination_hiz <= 1'b1;
            fields          <= '0;
        end
        else if (clk_en)
        begin
            state           <= next_state;
            init_cnt        <= next_init_cnt;
            lock_cnt        <= next_lock_cnt;
            cal_cnt         <= next_cal_cnt;
            lock_ran        <= next_lock_ran;
            cal_ran         <= next_cal_ran;
            mode_written    <= next_mode_written;
            termination_hiz <= next_termination_hiz;
            fields          <= next_fields;
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        ready          = (state == ST_READY);
        self_init_done = (state == ST_WAIT_CKE) || (state == ST_MODE) || ready;
        lock_busy      = (lock_cnt != '0);
        cal_busy       = (cal_cnt != '0);
        mode_reg_zero  = mreg[0];
        mode_reg_one   = mreg[1];
        mode_reg_two   = mreg[2];
        mode_reg_three = mreg[3];
    end

endmodule : dmis_seq

// file: dmis_seq_checker.sv
// ----------------------------------------------------------------
// Port checker for the initialisation sequencer
// ----------------------------------------------------------------
module dmis_seq_checker #(
    parameter int unsigned SELFINIT_CYC  = 20,
    parameter int unsigned LOCK_CYC      = 8,
    parameter int unsigned CAL_CYC       = 8,
    parameter int unsigned PRECHARGE_CYC = 8
) (
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   clk_en,
    input wire logic                   chip_reset_n,
    input wire logic                   cke,
    input wire dmis_pkg::dmis_cmd_t    cmd,
    input wire logic                   termination_hiz,
    input wire logic                   ready,
    input wire logic                   lock_busy,
    input wire logic                   cal_busy,
    input wire logic [3:0]             mode_written,
    input wire logic [15:0]            mode_reg_zero,
    input wire logic [15:0]            mode_reg_one,
    input wire logic [15:0]            mode_reg_two,
    input wire dmis_pkg::dmis_fields_t fields,
    input wire dmis_pkg::dmis_state_t  state
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmis_pkg::*;
    localparam int SI_LAST = SELFINIT_CYC - 1;
    localparam int LK_N    = LOCK_CYC;
    localparam int CAL_N   = CAL_CYC;
    logic load;
    logic cal_long;
    logic [1:0] bk;
    assign bk = cmd.bank_select[1:0];
    assign load = clk_en && chip_reset_n && cke && (state == ST_MODE || state == ST_READY)
                  && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n && !cmd.bank_select[2];
    assign cal_long = clk_en && chip_reset_n && cke && state == ST_MODE && !cmd.cs_n
                      && cmd.ras_n && cmd.cas_n && !cmd.we_n && cmd.addr[10];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chip_rst_a: assert property (clk_en && !chip_reset_n |=>
        termination_hiz && mode_written == 4'h0 && state == ST_RESET) else $error("chip reset missed");
    hiz_release_a: assert property ($fell(termination_hiz) |-> $past(cke))
        else $error("termination released without clock gate");
    mr_zero_a: assert property (load && bk == 2'h0 |=> mode_reg_zero == ($past(cmd.addr) & 16'hFEFF))
        else $error("register zero load wrong");
    mr_one_a: assert property (load && bk == 2'h1 |=> mode_reg_one == $past(cmd.addr))
        else $error("register one load wrong");
    mr_two_a: assert property (load && bk == 2'h2 |=> mode_reg_two == $past(cmd.addr))
        else $error("register two load wrong");
    cas_field_a: assert property (load && bk == 2'h0 |=>
        fields.cas_latency == 5'h04 + {1'b0, $past(cmd.addr[2]), $past(cmd.addr[6:4])})
        else $error("latency decode wrong");
    read_lat_a: assert property (fields.read_latency == fields.cas_latency + fields.additive_latency)
        else $error("read latency not sum");
    dal_sum_a: assert property (mode_written[0] |->
        fields.autoprecharge_write_delay == fields.write_recovery + PRECHARGE_CYC)
        else $error("write delay not sum");
    ready_gate_a: assert property ($rose(ready) |-> mode_written == 4'hF && !lock_busy && !cal_busy)
        else $error("ready too early");
    selfinit_len_a: assert property (disable iff (!rstn || !chip_reset_n || !clk_en)
        $rose(state == ST_SELFINIT) |-> ##SI_LAST state == ST_SELFINIT ##1 state == ST_WAIT_CKE)
        else $error("self init length wrong");
    lock_len_a: assert property (load && bk == 2'h0 && cmd.addr[8] |=> lock_busy ##LK_N !lock_busy)
        else $error("lock time wrong");
    cal_len_a: assert property (cal_long |=> cal_busy ##CAL_N !cal_busy)
        else $error("calibration time wrong");

    cover property ($rose(ready));
    cover property (load && bk == 2'h0 && cmd.addr[8]);
    cover property (clk_en && !chip_reset_n && ready);
endmodule : dmis_seq_checker

bind dmis_seq dmis_seq_checker #(.SELFINIT_CYC(SELFINIT_CYC), .LOCK_CYC(LOCK_CYC),
    .CAL_CYC(CAL_CYC), .PRECHARGE_CYC(PRECHARGE_CYC)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .clk_en(clk_en), .chip_reset_n(chip_reset_n), .cke(cke), .cmd(cmd),
    .termination_hiz(termination_hiz), .ready(ready), .lock_busy(lock_busy), .cal_busy(cal_busy),
    .mode_written(mode_written), .mode_reg_zero(mode_reg_zero), .mode_reg_one(mode_reg_one),
    .mode_reg_two(mode_reg_two), .fields(fields), .state(state));

// file: dmis_ctrl_model.sv
// ----------------------------------------------------------------
// Controller model: power-up and stable-power initialisation
// ----------------------------------------------------------------
module dmis_ctrl_model #(
    parameter int          RST_CYC    = 5000,
    parameter int          SHORT_CYC  = 3,
    parameter int          SELF_WAIT  = 24,
    parameter int          EXIT_CYC   = 5,
    parameter int          GAP_CYC    = 4,
    parameter logic [15:0] MODE_ZERO  = 16'h0530,
    parameter logic [15:0] MODE_ONE   = 16'h0008,
    parameter logic [15:0] MODE_TWO   = 16'h0018,
    parameter logic [15:0] MODE_THREE = 16'h0000
) (
    input  wire logic          clk_sys,
    input  wire logic          go,
    input  wire logic          short_rst,
    output logic               chip_reset_n,
    output logic               cke,
    output dmis_pkg::dmis_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmis_pkg::*;
    logic termination_ctrl_in;

    initial
    begin
        chip_reset_n = 1'b0;
        cke = 1'b0;
        cmd = {4'h7, 3'h0, 16'h0000};
        termination_ctrl_in = 1'b0;
    end

    task automatic issue(input logic [3:0] ctl, input logic [2:0] bank, input logic [15:0] val);
        cmd = {ctl, bank, val};
        @(negedge clk_sys);
        cmd = {4'h7, 3'h0, ~val};
        repeat (GAP_CYC) @(negedge clk_sys);
    endtask : issue

    always @(posedge go)
    begin
        @(negedge clk_sys);
        cke = 1'b0;
        chip_reset_n = 1'b0;
        repeat (short_rst ? SHORT_CYC : RST_CYC) @(negedge clk_sys);
        chip_reset_n = 1'b1;
        repeat (SELF_WAIT) @(negedge clk_sys);
        cke = 1'b1;
        repeat (EXIT_CYC) @(negedge clk_sys);
        issue(4'h0, 3'h2, MODE_TWO);
        issue(4'h0, 3'h3, MODE_THREE);
        issue(4'h0, 3'h1, MODE_ONE);
        issue(4'h0, 3'h0, MODE_ZERO);
        issue(4'h6, 3'h0, 16'h0400);
    end
endmodule : dmis_ctrl_model

// file: dram_init_mode_register_seq_test.sv
module dram_init_mode_register_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dmis_pkg::*;
    typedef struct packed
    {
        logic [2:0]  bank;
        logic [15:0] val;
        logic [19:0] exp;
    } dmis_row_t;
    logic clk_sys = 1'b0;
    logic rstn, clk_en, go, short_rst, tb_own, chip_reset_n, cke;
    logic termination_hiz, ready, self_init_done, lock_busy, cal_busy;
    logic [3:0]  mode_written;
    logic [15:0] mode_reg_zero, mode_reg_one, mode_reg_two, mode_reg_three;
    logic [19:0] fsum;
    dmis_cmd_t    cmd, tb_cmd, m_cmd;
    dmis_fields_t fields;
    dmis_state_t  state;
    dmis_row_t    rows [10];
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;
    assign cmd = tb_own ? tb_cmd : m_cmd;
    assign fsum = {fields.cas_latency, fields.additive_latency, fields.write_recovery,
                   fields.burst_len, fields.burst_interleave, fields.dll_disabled,
                   fields.test_mode};

    dmis_ctrl_model u_ctrl (.clk_sys(clk_sys), .go(go), .short_rst(short_rst),
        .chip_reset_n(chip_reset_n), .cke(cke), .cmd(m_cmd));
    dmis_seq #(.SELFINIT_CYC(20), .LOCK_CYC(8), .CAL_CYC(8), .PRECHARGE_CYC(8)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .chip_reset_n(chip_reset_n),
        .cke(cke), .cmd(cmd), .termination_hiz(termination_hiz), .ready(ready),
        .self_init_done(self_init_done), .lock_busy(lock_busy), .cal_busy(cal_busy),
        .mode_written(mode_written), .mode_reg_zero(mode_reg_zero), .mode_reg_one(mode_reg_one),
        .mode_reg_two(mode_reg_two), .mode_reg_three(mode_reg_three), .fields(fields),
        .state(state));

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic load(input logic [2:0] bank, input logic [15:0] val);
        tb_cmd = {4'h0, bank, val};
        @(negedge clk_sys);
        tb_cmd = {4'hF, 3'h0, ~val};
        repeat (5) @(negedge clk_sys);
    endtask : load

    task automatic wait_rdy();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk({18'h0, self_init_done, ready}, 20'h00003);
    endtask : wait_rdy

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        rows = '{'{3'h0, 16'h0000, {5'h04, 5'h03, 5'h10, 4'h0, 1'b0}},
                 '{3'h0, 16'h020D, {5'h0C, 5'h0B, 5'h05, 4'h6, 1'b0}},
                 '{3'h0, 16'h0412, {5'h05, 5'h04, 5'h06, 4'h8, 1'b0}},
                 '{3'h0, 16'h0670, {5'h0B, 5'h0A, 5'h07, 4'h0, 1'b0}},
                 '{3'h0, 16'h0834, {5'h0F, 5'h0E, 5'h08, 4'h0, 1'b0}},
                 '{3'h0, 16'h0A40, {5'h08, 5'h07, 5'h0A, 4'h0, 1'b0}},
                 '{3'h0, 16'h0C28, {5'h06, 5'h05, 5'h0C, 4'h2, 1'b0}},
                 '{3'h0, 16'h0E60, {5'h0A, 5'h09, 5'h0E, 4'h0, 1'b0}},
                 '{3'h1, 16'h0011, {5'h0A, 5'h08, 5'h0E, 4'h1, 1'b0}},
                 '{3'h1, 16'h0018, {5'h0A, 5'h00, 5'h0E, 4'h0, 1'b0}}};
        rstn = 1'b0;
        clk_en = 1'b1;
        go = 1'b0;
        short_rst = 1'b0;
        tb_own = 1'b0;
        tb_cmd = {4'hF, 3'h0, 16'h0000};
        repeat (8) @(negedge clk_sys);
        chk({termination_hiz, mode_written, 12'h0, state}, {1'b1, 4'h0, 12'h0, ST_RESET});
        rstn = 1'b1;
        go = 1'b1;
        @(posedge chip_reset_n);
        repeat (3) @(negedge clk_sys);
        chk({termination_hiz, self_init_done, 15'h0, state}, {2'h2, 15'h0, ST_SELFINIT});
        wait_rdy();
        chk({4'h0, mode_reg_zero}, 20'h00430);
        chk({4'h0, mode_reg_one}, 20'h00008);
        chk({4'h0, mode_reg_two}, 20'h00018);
        chk({termination_hiz, mode_written, mode_reg_three[14:0]}, {1'b0, 4'hF, 15'h0});
        chk(fsum, {5'h07, 5'h06, 5'h06, 4'h0, 1'b0});
        chk({6'h0, fields.read_latency, fields.autoprecharge_write_delay}, 20'h00D0E);
        tb_own = 1'b1;
        foreach (rows[i])
        begin
            load(rows[i].bank, rows[i].val);
            chk(fsum, rows[i].exp);
        end
        load(3'h4, 16'hFFFF);
        chk({mode_reg_zero[9:0], mode_reg_one[9:0]}, {10'h260, 10'h018});
        clk_en = 1'b0;
        load(3'h3, 16'h1234);
        clk_en = 1'b1;
        chk({4'h0, mode_reg_three}, 20'h00000);
        load(3'h3, 16'h0003);
        chk({4'h0, mode_reg_three}, 20'h00003);
        tb_own = 1'b0;
        go = 1'b0;
        short_rst = 1'b1;
        @(negedge clk_sys);
        go = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({termination_hiz, ready, mode_written, 14'h0}, {2'h2, 4'h0, 14'h0});
        wait_rdy();
        chk({mode_written, mode_reg_zero}, {4'hF, 16'h0430});
        rstn = 1'b0;
        @(negedge clk_sys);
        chk({termination_hiz, mode_reg_zero, state}, {1'b1, 16'h0000, ST_RESET});
        rstn = 1'b1;
        stop_test();
    end
endmodule : dram_init_mode_register_seq_test
